// *** hw/blc_pkg.sv ***
/*
 * Shared constants, state type and helper function for the black level
 * calibration control block.
 * Assumes a single 100 MHz clock domain and a 16-bit register port.
 */
package blc_pkg;

    // register port geometry and data widths
    localparam int REG_AW = 8;
    localparam int REG_DW = 16;
    localparam int CAL_W = 9;
    localparam int AVG_W = 7;
    localparam int ROW_W = 4;

    // register offsets
    localparam logic [7:0] CTRL_OFS = 8'h60;
    localparam logic [7:0] G1_OFS = 8'h61;

    // control and green1 register field positions
    localparam int CTRL_DIS_RAPID_B = 15;
    localparam int CTRL_RECALC_B = 12;
    localparam int CTRL_LIMIT_B = 10;
    localparam int CTRL_FREEZE_B = 9;
    localparam int CTRL_SWEEP_B = 8;
    localparam int CTRL_DEPTH_LSB = 5;
    localparam int CTRL_UNIT_STEP_B = 4;
    localparam int CTRL_SAME_RB_B = 2;
    localparam int CTRL_SAME_G_B = 1;
    localparam int CTRL_OVR_B = 0;
    localparam int G1_SIGN_B = 8;

    // values after reset
    localparam logic [2:0] DEPTH_RST = 3'h4;
    localparam logic [CAL_W-1:0] G1_RST = 9'h000;
    localparam logic [AVG_W-1:0] AVG_RST = 7'h00;

    // sweep loop constants
    localparam logic [CAL_W-1:0] STEP_INIT = 9'h008;
    localparam logic [CAL_W-1:0] STEP_UNIT = 9'h001;
    localparam logic [AVG_W-1:0] THR_LOW = 7'h1d;
    localparam logic [AVG_W-1:0] THR_HIGH = 7'h23;

    // dark rows that seed the frame-wise algorithm when limiting
    localparam logic [ROW_W-1:0] SEED_ROW_FIRST = 4'h8;
    localparam logic [ROW_W-1:0] SEED_ROW_LAST = 4'hb;
    localparam int SEED_SHIFT = 2;

    typedef enum logic [1:0] {
        BLC_ST_AVG = 2'b01,
        BLC_ST_RAPID = 2'b10
    } blc_state_e;

    // saturating signed add (up) or subtract (down) of a step to a calibration offset
    function automatic logic [CAL_W-1:0] blc_cal_step(
        input logic [CAL_W-1:0] cal,
        input logic [CAL_W-1:0] step,
        input logic up
    );
        logic signed [CAL_W+1:0] sum;
        sum = up ? ($signed({cal[CAL_W-1], cal[CAL_W-1], cal}) + $signed({2'b00, step}))
                 : ($signed({cal[CAL_W-1], cal[CAL_W-1], cal}) - $signed({2'b00, step}));
        if (sum > $signed(11'h0ff))
            return 9'h0ff;
        else if (sum < $signed(11'h700))
            return 9'h100;
        else
            return sum[CAL_W-1:0];
    endfunction : blc_cal_step

endpackage : blc_pkg

// *** hw/blc_cal_if.sv ***
/*
 * Link between the register bank and the calibration engine.
 * Assumes both ends share ref_clk_i and the clock enable carried here.
 */
`timescale 1ns/1ps
interface blc_cal_if;
    logic ce;
    logic frame_stb;
    logic [blc_pkg::AVG_W-1:0] frame_avg;
    logic recalc;
    logic dis_rapid;
    logic freeze;
    logic sweep;
    logic [2:0] depth;
    logic unit_step;
    logic [blc_pkg::CAL_W-1:0] cal;
    logic [blc_pkg::AVG_W-1:0] run_avg;
    logic rapid_on;

    modport ctrl (
        output ce, frame_stb, frame_avg, recalc, dis_rapid, freeze, sweep, depth, unit_step,
        input cal, run_avg, rapid_on
    );
    modport eng (
        input ce, frame_stb, frame_avg, recalc, dis_rapid, freeze, sweep, depth, unit_step,
        output cal, run_avg, rapid_on
    );
endinterface : blc_cal_if

// *** hw/blc_engine.sv ***
/*
 * Frame-wise green1 calibration engine: running average, rapid sweep
 * and averaging loop, ramp mode and freeze.
 * Assumes one frame_stb pulse per frame carrying that frame's dark average.
 */
`timescale 1ns/1ps
module blc_engine (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    blc_cal_if.eng cif
);
    blc_pkg::blc_state_e state_reg, state_next;
    logic [blc_pkg::CAL_W-1:0] cal_reg, cal_next;
    logic [blc_pkg::CAL_W-1:0] step_reg, step_next;
    logic [blc_pkg::AVG_W-1:0] run_reg, run_next;
    logic [blc_pkg::AVG_W-1:0] cmp_avg;
    logic hi;
    logic lo;

    // next state of the loop, evaluated once per frame
    always_comb
    begin
        state_next = state_reg;
        cal_next = cal_reg;
        step_next = step_reg;
        run_next = run_reg;
        if (cif.recalc)
            run_next = cif.frame_avg;
        else
            run_next = blc_pkg::AVG_W'(run_reg - (run_reg >> cif.depth)
                + (cif.frame_avg >> cif.depth));
        cmp_avg = (state_reg == blc_pkg::BLC_ST_RAPID) ? cif.frame_avg : run_next;
        hi = cmp_avg > blc_pkg::THR_HIGH;
        lo = cmp_avg < blc_pkg::THR_LOW;
        if (!cif.frame_stb)
        begin
            run_next = run_reg;
        end
        else if (cif.freeze)
        begin
            state_next = state_reg;
        end
        else if (cif.sweep)
        begin
            cal_next = blc_pkg::CAL_W'(cal_reg + blc_pkg::STEP_UNIT);
        end
        else if (cif.recalc && !cif.dis_rapid)
        begin
            // a recalc restarts the sweep from its first step, even mid-sweep
            state_next = blc_pkg::BLC_ST_RAPID;
            step_next = cif.unit_step ? blc_pkg::STEP_UNIT
                                      : blc_pkg::STEP_INIT;
        end
        else
        begin
            case (state_reg)
                blc_pkg::BLC_ST_AVG:
                begin
                    if (hi || lo)
                        cal_next = blc_pkg::blc_cal_step(cal_reg, blc_pkg::STEP_UNIT, lo);
                end
                blc_pkg::BLC_ST_RAPID:
                begin
                    if (cif.dis_rapid || !(hi || lo))
                        state_next = blc_pkg::BLC_ST_AVG;
                    else
                    begin
                        cal_next = blc_pkg::blc_cal_step(cal_reg, step_reg, lo);
                        step_next = (step_reg > blc_pkg::STEP_UNIT) ? (step_reg >> 1)
                                                                    : blc_pkg::STEP_UNIT;
                    end
                end
                default:
                    state_next = blc_pkg::BLC_ST_AVG;
            endcase
        end
    end

    // loop registers, frozen while the clock enable is low
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_reg <= blc_pkg::BLC_ST_AVG;
            cal_reg <= blc_pkg::G1_RST;
            step_reg <= blc_pkg::STEP_UNIT;
            run_reg <= blc_pkg::AVG_RST;
        end
        else if (cif.ce)
        begin
            state_reg <= state_next;
            cal_reg <= cal_next;
            step_reg <= step_next;
            run_reg <= run_next;
        end
    end

    assign cif.cal = cal_reg;
    assign cif.run_avg = run_reg;
    assign cif.rapid_on = (state_reg == blc_pkg::BLC_ST_RAPID);

endmodule : blc_engine

// *** hw/blc_calib_ctrl.sv ***
/*
 * Black level calibration control: control register, green1 offset
 * register, per-channel offset selection and dark row routing.
 * Assumes a synchronous register port, a frame pulse with the loop's dark
 * average, and the other channels' offsets supplied from outside.
 */
`timescale 1ns/1ps
module blc_calib_ctrl (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    input wire logic [blc_pkg::REG_AW-1:0] reg_addr_i,
    input wire logic [blc_pkg::REG_DW-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [blc_pkg::REG_DW-1:0] reg_rdata_o,
    input wire logic frame_stb_i,
    input wire logic [blc_pkg::AVG_W-1:0] frame_avg_i,
    input wire logic row_vld_i,
    input wire logic [blc_pkg::ROW_W-1:0] row_idx_i,
    input wire logic [blc_pkg::AVG_W-1:0] row_avg_i,
    output logic loop_row_use_o,
    output logic [blc_pkg::AVG_W-1:0] seed_avg_o,
    output logic [blc_pkg::AVG_W-1:0] run_avg_o,
    output logic rapid_active_o,
    input wire logic [blc_pkg::CAL_W-1:0] cal_red_i,
    input wire logic [blc_pkg::CAL_W-1:0] cal_blue_i,
    input wire logic [blc_pkg::CAL_W-1:0] cal_green2_i,
    output logic [blc_pkg::CAL_W-1:0] cal_green1_o,
    output logic [blc_pkg::CAL_W-1:0] cal_green2_o,
    output logic [blc_pkg::CAL_W-1:0] cal_red_o,
    output logic [blc_pkg::CAL_W-1:0] cal_blue_o
);
    blc_cal_if cif ();

    // control fields
    logic dis_rapid_reg, dis_rapid_next;
    logic limit_reg, limit_next;
    logic freeze_reg, freeze_next;
    logic sweep_reg, sweep_next;
    logic [2:0] depth_reg, depth_next;
    logic unit_step_reg, unit_step_next;
    logic same_rb_reg, same_rb_next;
    logic same_g_reg, same_g_next;
    logic ovr_reg, ovr_next;
    logic recalc_reg, recalc_next;
    logic [blc_pkg::CAL_W-1:0] g1_man_reg, g1_man_next;
    logic [blc_pkg::REG_DW-1:0] rdata_reg, rdata_next;
    logic [blc_pkg::AVG_W+1:0] seed_sum_reg, seed_sum_next;
    logic [blc_pkg::AVG_W-1:0] seed_reg, seed_next;
    logic [blc_pkg::CAL_W-1:0] g1_reg, g1_next;
    logic [blc_pkg::CAL_W-1:0] g2_reg, g2_next;
    logic [blc_pkg::CAL_W-1:0] red_reg, red_next;
    logic [blc_pkg::CAL_W-1:0] blue_reg, blue_next;
    logic wr_ctrl;
    logic wr_g1;
    logic seed_row;
    logic [blc_pkg::CAL_W-1:0] g1_applied;
    logic [blc_pkg::REG_DW-1:0] ctrl_view;

    // register port decode
    assign wr_ctrl = reg_wr_i && (reg_addr_i == blc_pkg::CTRL_OFS);
    assign wr_g1 = reg_wr_i && (reg_addr_i == blc_pkg::G1_OFS);

    // control register image; recalc and reserved bits read as zero
    always_comb
    begin
        ctrl_view = '0;
        ctrl_view[blc_pkg::CTRL_DIS_RAPID_B] = dis_rapid_reg;
        ctrl_view[blc_pkg::CTRL_RECALC_B] = 1'b0;
        ctrl_view[blc_pkg::CTRL_LIMIT_B] = limit_reg;
        ctrl_view[blc_pkg::CTRL_FREEZE_B] = freeze_reg;
        ctrl_view[blc_pkg::CTRL_SWEEP_B] = sweep_reg;
        ctrl_view[blc_pkg::CTRL_DEPTH_LSB +: 3] = depth_reg;
        ctrl_view[blc_pkg::CTRL_UNIT_STEP_B] = unit_step_reg;
        ctrl_view[blc_pkg::CTRL_SAME_RB_B] = same_rb_reg;
        ctrl_view[blc_pkg::CTRL_SAME_G_B] = same_g_reg;
        ctrl_view[blc_pkg::CTRL_OVR_B] = ovr_reg;
    end

    // green1 value in force: manual when overridden, else computed
    assign g1_applied = ovr_reg ? g1_man_reg : cif.cal;

    // register writes, recalc request and read data
    always_comb
    begin
        dis_rapid_next = dis_rapid_reg;
        limit_next = limit_reg;
        freeze_next = freeze_reg;
        sweep_next = sweep_reg;
        depth_next = depth_reg;
        unit_step_next = unit_step_reg;
        same_rb_next = same_rb_reg;
        same_g_next = same_g_reg;
        ovr_next = ovr_reg;
        g1_man_next = g1_man_reg;
        rdata_next = rdata_reg;
        // pending recalc is consumed at the frame; a new write wins
        recalc_next = recalc_reg && !frame_stb_i;
        if (wr_ctrl)
        begin
            dis_rapid_next = reg_wdata_i[blc_pkg::CTRL_DIS_RAPID_B];
            limit_next = reg_wdata_i[blc_pkg::CTRL_LIMIT_B];
            freeze_next = reg_wdata_i[blc_pkg::CTRL_FREEZE_B];
            sweep_next = reg_wdata_i[blc_pkg::CTRL_SWEEP_B];
            depth_next = reg_wdata_i[blc_pkg::CTRL_DEPTH_LSB +: 3];
            unit_step_next = reg_wdata_i[blc_pkg::CTRL_UNIT_STEP_B];
            same_rb_next = reg_wdata_i[blc_pkg::CTRL_SAME_RB_B];
            same_g_next = reg_wdata_i[blc_pkg::CTRL_SAME_G_B];
            ovr_next = reg_wdata_i[blc_pkg::CTRL_OVR_B];
            if (reg_wdata_i[blc_pkg::CTRL_RECALC_B])
                recalc_next = 1'b1;
        end
        if (wr_g1 && ovr_reg)
            g1_man_next = reg_wdata_i[blc_pkg::CAL_W-1:0];
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                blc_pkg::CTRL_OFS:
                    rdata_next = ctrl_view;
                blc_pkg::G1_OFS:
                    rdata_next = {7'h00, g1_applied};
                default:
                    rdata_next = '0;
            endcase
        end
    end

    // dark row routing and seed averaging of rows 8 to 11
    assign seed_row = limit_reg && (row_idx_i >= blc_pkg::SEED_ROW_FIRST)
        && (row_idx_i <= blc_pkg::SEED_ROW_LAST);
    assign loop_row_use_o = row_vld_i && !seed_row;

    always_comb
    begin
        seed_sum_next = seed_sum_reg;
        seed_next = seed_reg;
        if (frame_stb_i)
        begin
            seed_next = blc_pkg::AVG_W'(seed_sum_reg >> blc_pkg::SEED_SHIFT);
            seed_sum_next = '0;
        end
        else if (row_vld_i && seed_row)
            seed_sum_next = (blc_pkg::AVG_W+2)'(seed_sum_reg + row_avg_i);
    end

    // per-channel offsets driven to the analog offset DACs
    always_comb
    begin
        g1_next = g1_applied;
        red_next = cal_red_i;
        g2_next = same_g_reg ? g1_applied : cal_green2_i;
        blue_next = same_rb_reg ? cal_red_i : cal_blue_i;
        if (sweep_reg && !ovr_reg)
        begin
            red_next = cif.cal;
            g2_next = cif.cal;
            blue_next = cif.cal;
        end
    end

    // state registers, all held while the clock enable is low
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            dis_rapid_reg <= 1'b0;
            limit_reg <= 1'b0;
            freeze_reg <= 1'b0;
            sweep_reg <= 1'b0;
            depth_reg <= blc_pkg::DEPTH_RST;
            unit_step_reg <= 1'b0;
            same_rb_reg <= 1'b0;
            same_g_reg <= 1'b0;
            ovr_reg <= 1'b0;
            recalc_reg <= 1'b0;
            g1_man_reg <= blc_pkg::G1_RST;
            rdata_reg <= '0;
            seed_sum_reg <= '0;
            seed_reg <= blc_pkg::AVG_RST;
            g1_reg <= blc_pkg::G1_RST;
            g2_reg <= blc_pkg::G1_RST;
            red_reg <= blc_pkg::G1_RST;
            blue_reg <= blc_pkg::G1_RST;
        end
        else if (clk_en_i)
        begin
            dis_rapid_reg <= dis_rapid_next;
            limit_reg <= limit_next;
            freeze_reg <= freeze_next;
            sweep_reg <= sweep_next;
            depth_reg <= depth_next;
            unit_step_reg <= unit_step_next;
            same_rb_reg <= same_rb_next;
            same_g_reg <= same_g_next;
            ovr_reg <= ovr_next;
            recalc_reg <= recalc_next;
            g1_man_reg <= g1_man_next;
            rdata_reg <= rdata_next;
            seed_sum_reg <= seed_sum_next;
            seed_reg <= seed_next;
            g1_reg <= g1_next;
            g2_reg <= g2_next;
            red_reg <= red_next;
            blue_reg <= blue_next;
        end
    end

    // engine hookup
    assign cif.ce = clk_en_i;
    assign cif.frame_stb = frame_stb_i;
    assign cif.frame_avg = frame_avg_i;
    assign cif.recalc = recalc_reg;
    assign cif.dis_rapid = dis_rapid_reg;
    assign cif.freeze = freeze_reg;
    assign cif.sweep = sweep_reg;
    assign cif.depth = depth_reg;
    assign cif.unit_step = unit_step_reg;

    blc_engine u_engine (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .cif(cif)
    );

    // outputs
    assign reg_rdata_o = rdata_reg;
    assign seed_avg_o = seed_reg;
    assign run_avg_o = cif.run_avg;
    assign rapid_active_o = cif.rapid_on;
    assign cal_green1_o = g1_reg;
    assign cal_green2_o = g2_reg;
    assign cal_red_o = red_reg;
    assign cal_blue_o = blue_reg;

    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_recalc_wr;
        clk_en_i && wr_ctrl && reg_wdata_i[blc_pkg::CTRL_RECALC_B];
    endsequence

    sequence s_frame_taken;
        clk_en_i && frame_stb_i && recalc_reg;
    endsequence

    a_recalc_pending: assert property (s_recalc_wr |=> recalc_reg)
        else $error("recalc write did not arm");
    a_run_reload: assert property (s_frame_taken |=> cif.run_avg == $past(frame_avg_i))
        else $error("running average not reloaded");
    a_recalc_reads_zero: assert property (clk_en_i && reg_rd_i
        && reg_addr_i == blc_pkg::CTRL_OFS |=> !reg_rdata_o[blc_pkg::CTRL_RECALC_B])
        else $error("recalc bit read back as one");
    a_limit_row_seed: assert property (row_vld_i && limit_reg
        && row_idx_i inside {[4'h8:4'hb]} |-> !loop_row_use_o)
        else $error("seed row reached the loop");
    a_nolimit_all_rows: assert property (row_vld_i && !limit_reg |-> loop_row_use_o)
        else $error("dark row dropped without limit");
    a_sweep_ramp: assert property (clk_en_i && frame_stb_i && sweep_reg && !freeze_reg
        |=> cif.cal == 9'($past(cif.cal) + 9'h001))
        else $error("sweep did not step by one");
    a_freeze_hold: assert property (clk_en_i && freeze_reg |=> $stable(cif.cal))
        else $error("calibration moved while frozen");
    a_g1_write_ignored: assert property (clk_en_i && wr_g1 && !ovr_reg
        |=> $stable(g1_man_reg))
        else $error("green1 written without override");
    a_g1_read_auto: assert property (clk_en_i && reg_rd_i && !ovr_reg
        && reg_addr_i == blc_pkg::G1_OFS |=> reg_rdata_o == {7'h00, $past(cif.cal)})
        else $error("green1 read not the computed value");
    a_share_green: assert property (clk_en_i && same_g_reg && !sweep_reg
        |=> cal_green2_o == cal_green1_o)
        else $error("green2 not sharing green1");
    a_share_rb: assert property (clk_en_i && same_rb_reg && !sweep_reg
        |=> cal_blue_o == cal_red_o)
        else $error("blue not sharing red");
    // the loop only leaves rapid sweep at a frame that is neither frozen nor ramping
    a_rapid_disabled: assert property (clk_en_i && frame_stb_i && dis_rapid_reg
        && !freeze_reg && !sweep_reg |=> !rapid_active_o)
        else $error("rapid sweep ran while disabled");

endmodule : blc_calib_ctrl

// *** test/black_level_calib_control_test.sv ***
/*
 * Self-checking bench for the black level calibration control block.
 * Assumes the design files under hw/ are compiled ahead of it.
 */
`timescale 1ns/1ps
module black_level_calib_control_test;
    logic ref_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic clk_en_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [15:0] reg_rdata_o;
    logic frame_stb_i = 1'b0;
    logic [6:0] frame_avg_i = 7'h00;
    logic row_vld_i = 1'b0;
    logic [3:0] row_idx_i = 4'h0;
    logic [6:0] row_avg_i = 7'h00;
    logic loop_row_use_o;
    logic rapid_active_o;
    logic [6:0] seed_avg_o;
    logic [6:0] run_avg_o;
    logic [8:0] cal_red_i = 9'h000;
    logic [8:0] cal_blue_i = 9'h000;
    logic [8:0] cal_green2_i = 9'h000;
    logic [8:0] cal_green1_o;
    logic [8:0] cal_green2_o;
    logic [8:0] cal_red_o;
    logic [8:0] cal_blue_o;
    int num_errors = 0;
    int n_tests = 0;
    int seed = 32'h28b3;
    int cycles = 0;

    blc_calib_ctrl i_blc_calib_ctrl (
        .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .frame_stb_i(frame_stb_i),
        .frame_avg_i(frame_avg_i), .row_vld_i(row_vld_i), .row_idx_i(row_idx_i),
        .row_avg_i(row_avg_i), .loop_row_use_o(loop_row_use_o), .seed_avg_o(seed_avg_o),
        .run_avg_o(run_avg_o), .rapid_active_o(rapid_active_o), .cal_red_i(cal_red_i),
        .cal_blue_i(cal_blue_i), .cal_green2_i(cal_green2_i), .cal_green1_o(cal_green1_o),
        .cal_green2_o(cal_green2_o), .cal_red_o(cal_red_o), .cal_blue_o(cal_blue_o)
    );

    // free running 100 MHz clock
    always #5 ref_clk_i = ~ref_clk_i;

    // hang guard
    always @(posedge ref_clk_i)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            num_errors++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic reg_write(input logic [7:0] addr, input logic [15:0] data);
        reg_addr_i = addr;
        reg_wdata_i = data;
        reg_wr_i = 1'b1;
        @(posedge ref_clk_i);
        #1;
        reg_wr_i = 1'b0;
        // idle edge so a following call never re-raises the strobe at once
        @(posedge ref_clk_i);
        #1;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] addr, output logic [15:0] data);
        reg_addr_i = addr;
        reg_rd_i = 1'b1;
        @(posedge ref_clk_i);
        #1;
        reg_rd_i = 1'b0;
        data = reg_rdata_o;
        // idle edge so a following call never re-raises the strobe at once
        @(posedge ref_clk_i);
        #1;
    endtask : reg_read

    // one frame pulse, then wait until the applied offsets have settled
    task automatic frame(input logic [6:0] avg);
        frame_avg_i = avg;
        frame_stb_i = 1'b1;
        @(posedge ref_clk_i);
        #1;
        frame_stb_i = 1'b0;
        repeat (2) @(posedge ref_clk_i);
        #1;
    endtask : frame

    // running average after one more frame at depth n
    function automatic logic [6:0] avg_next(input logic [6:0] old, input logic [6:0] nw,
                                            input int n);
        return old - (old >> n) + (nw >> n);
    endfunction : avg_next

    // main sequence
    initial
    begin
        logic [15:0] rd;
        logic [8:0] c0;
        logic [8:0] v;
        logic [8:0] sum;
        logic [6:0] a;
        int n;
        repeat (8) @(posedge ref_clk_i);
        #1;
        rst_b_i = 1'b1;
        reg_read(blc_pkg::CTRL_OFS, rd);
        check("ctrl reset", rd, 16'h0080);
        reg_read(8'h62, rd);
        check("unmapped read", rd, 16'h0000);
        reg_write(blc_pkg::G1_OFS, 16'h0055);
        reg_read(blc_pkg::G1_OFS, rd);
        check("green1 read only", rd, 16'h0000);
        // ramp mode, all channels equal
        cal_red_i = 9'($random(seed));
        cal_blue_i = 9'($random(seed));
        cal_green2_i = 9'($random(seed));
        reg_write(blc_pkg::CTRL_OFS, 16'h0180);
        frame(7'($random(seed)));
        repeat (3)
        begin
            c0 = cal_green1_o;
            frame(7'($random(seed)));
            check("ramp step", 16'(cal_green1_o), 16'(c0 + 9'h001));
            check("ramp red", 16'(cal_red_o), 16'(cal_green1_o));
            check("ramp blue", 16'(cal_blue_o), 16'(cal_green1_o));
            check("ramp green2", 16'(cal_green2_o), 16'(cal_green1_o));
        end
        // freeze holds the offset
        reg_write(blc_pkg::CTRL_OFS, 16'h0380);
        c0 = cal_green1_o;
        frame(7'h7f);
        check("freeze hold", 16'(cal_green1_o), 16'(c0));
        // recalculate reload, rapid disable, running average per depth
        for (int i = 0; i < 8; i++)
        begin
            n = i;
            a = 7'($random(seed));
            reg_write(blc_pkg::CTRL_OFS, {i[0], 3'h1, 4'h0, n[2:0], 5'h00});
            frame(a);
            check("reload", 16'(run_avg_o), 16'(a));
            check("rapid on", 16'(rapid_active_o), 16'(!i[0]));
            v = 9'($random(seed));
            frame(v[6:0]);
            check("run avg", 16'(run_avg_o), 16'(avg_next(a, v[6:0], n)));
        end
        // step size, forced unit then default larger start
        for (int u = 1; u >= 0; u--)
        begin
            reg_write(blc_pkg::CTRL_OFS, u ? 16'h1090 : 16'h1080);
            c0 = cal_green1_o;
            repeat (3) frame(7'h7f);
            v = c0 - cal_green1_o;
            check("step", 16'(u ? (v == 2 || v == 3) : (v >= 8 && v <= 15)), 16'h0001);
        end
        // reserved bits, manual override and channel sharing
        reg_write(blc_pkg::CTRL_OFS, 16'h7889);
        reg_read(blc_pkg::CTRL_OFS, rd);
        check("ctrl reserved", rd, 16'h0081);
        for (int s = 0; s < 4; s++)
        begin
            v = 9'($random(seed));
            cal_red_i = 9'($random(seed));
            cal_blue_i = 9'($random(seed));
            cal_green2_i = 9'($random(seed));
            reg_write(blc_pkg::CTRL_OFS, 16'h0081 | 16'(s << 1));
            reg_write(blc_pkg::G1_OFS, {7'h7f, v});
            reg_read(blc_pkg::G1_OFS, rd);
            check("green1 manual", rd, {7'h00, v});
            check("green1 out", 16'(cal_green1_o), 16'(v));
            check("red out", 16'(cal_red_o), 16'(cal_red_i));
            check("blue out", 16'(cal_blue_o), 16'(s[1] ? cal_red_i : cal_blue_i));
            check("green2 out", 16'(cal_green2_o), 16'(s[0] ? v : cal_green2_i));
        end
        // dark row routing and seed average
        reg_write(blc_pkg::CTRL_OFS, 16'h0480);
        sum = 9'h000;
        for (int r = 0; r < 12; r++)
        begin
            row_vld_i = 1'b1;
            row_idx_i = 4'(r);
            row_avg_i = 7'($random(seed));
            if (r >= 8)
                sum = sum + 9'(row_avg_i);
            #1;
            check("row use limited", 16'(loop_row_use_o), 16'(r < 8));
            @(posedge ref_clk_i);
            #1;
        end
        row_vld_i = 1'b0;
        frame(7'h20);
        check("seed avg", 16'(seed_avg_o), 16'(sum[8:2]));
        reg_write(blc_pkg::CTRL_OFS, 16'h0080);
        row_vld_i = 1'b1;
        row_idx_i = 4'h9;
        #1;
        check("row use all", 16'(loop_row_use_o), 16'h0001);
        @(posedge ref_clk_i);
        #1;
        row_vld_i = 1'b0;
        // disabled clock ignores a write
        clk_en_i = 1'b0;
        reg_write(blc_pkg::CTRL_OFS, 16'h0001);
        clk_en_i = 1'b1;
        reg_read(blc_pkg::CTRL_OFS, rd);
        check("clock enable", rd, 16'h0080);
        end_of_test();
    end

endmodule : black_level_calib_control_test
